/* hw/mpc_codec.sv */
// mpc_codec: builds outgoing management payload octets, parses incoming ones
// assumes a byte-wide framer downstream that honours tx_ready/tx_last
`timescale 1ns/1ps
`default_nettype none
module mpc_codec (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_type,
  input wire logic [7:0] cmd_node,
  input wire logic [7:0] cmd_multicast_stream_id,
  input wire logic [7:0] cmd_peer,
  input wire logic [7:0] cmd_peer2,
  input wire logic cmd_flag,
  input wire logic [7:0] cmd_count,
  input wire logic [31:0] cmd_bw,
  input wire logic [15:0] cmd_rate,
  input wire logic [7:0] cmd_dest,
  input wire logic list_valid,
  output logic list_ready,
  input wire logic [7:0] list_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [7:0] tx_dest,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [2:0] rx_type,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic p_valid,
  output logic [2:0] p_type,
  output logic [7:0] p_node,
  output logic [7:0] p_multicast_stream_id,
  output logic [7:0] p_peer,
  output logic [7:0] p_peer2,
  output logic [7:0] p_tag,
  output logic [7:0] p_code,
  output logic [7:0] p_count,
  output logic [31:0] p_bw,
  output logic [15:0] p_rate,
  output logic p_unsup,
  output logic p_bad_len,
  output logic p_item_valid,
  output logic [7:0] p_item,
  output logic tag_held
);
  typedef enum logic {G_IDLE, G_SEND} mpc_gen_e;

  typedef struct packed {
    mpc_gen_e st;
    mpc_pkg::mpc_msg_e mt;
    logic [8:0] idx, len;
    logic [7:0] node, multicast_stream_id, peer, peer2, tag, code, cnt, dest;
    logic [31:0] bw;
    logic [15:0] rate;
    logic [7:0] r_src, r_multicast_stream_id, r_client, r_tag;
    logic r_have;
    logic ov, ol;
    logic [7:0] od, odest;
    mpc_pkg::mpc_msg_e omt;
  } mpc_gen_s;

  mpc_gen_s s_q, s_d;

  // octet at position idx of the message held in g; list octets come elsewhere
  // the layout is fixed whatever bandplan either node runs
  function automatic logic [7:0] build_octet(mpc_gen_s g);
    build_octet = 8'h00;
    unique case (g.mt)
      mpc_pkg::MT_PREL_CNF: begin
        case (g.idx)
          mpc_pkg::O_PR_SRC: build_octet = g.node;
          mpc_pkg::O_PR_MULTICAST_STREAM_ID: build_octet = g.multicast_stream_id;
          mpc_pkg::O_PR_CLIENT: build_octet = g.peer;
          mpc_pkg::O_PR_TAG: build_octet = g.tag;
          default: build_octet = g.code;
        endcase
      end
      mpc_pkg::MT_BROKEN: begin
        case (g.idx)
          mpc_pkg::O_PR_SRC: build_octet = g.node;
          mpc_pkg::O_BL_REP: build_octet = g.peer;
          mpc_pkg::O_BL_LOST: build_octet = g.peer2;
          mpc_pkg::O_BL_STAT: build_octet = g.code;
          default: build_octet = g.cnt;
        endcase
      end
      mpc_pkg::MT_RSV_REQ: begin
        case (g.idx)
          mpc_pkg::O_PR_SRC: build_octet = g.node;
          mpc_pkg::O_PR_MULTICAST_STREAM_ID: build_octet = g.multicast_stream_id;
          mpc_pkg::O_RQ_GAP: build_octet = mpc_pkg::RSV_GAP;
          mpc_pkg::O_RQ_BW: build_octet = g.bw[7:0];
          mpc_pkg::O_RQ_BW + 9'h1: build_octet = g.bw[15:8];
          mpc_pkg::O_RQ_BW + 9'h2: build_octet = g.bw[23:16];
          mpc_pkg::O_RQ_BW + 9'h3: build_octet = g.bw[31:24];
          mpc_pkg::O_RQ_RATE: build_octet = g.rate[7:0];
          default: build_octet = g.rate[15:8];
        endcase
      end
      mpc_pkg::MT_RSV_CNF: begin
        case (g.idx)
          mpc_pkg::O_RC_STAT: build_octet = g.code;
          mpc_pkg::O_RC_NODE: build_octet = g.node;
          default: build_octet = g.multicast_stream_id;
        endcase
      end
      mpc_pkg::MT_REL_CNF:
        build_octet = (g.idx == mpc_pkg::O_LC_MULTICAST_STREAM_ID) ? g.multicast_stream_id : g.node;
      default:
        build_octet = (g.idx == mpc_pkg::O_PR_SRC) ? g.node : g.multicast_stream_id;
    endcase
  endfunction : build_octet

  logic prs_valid;
  logic [2:0] prs_type;
  logic prs_unsup;
  logic prs_bad;

  mpc_parse u_parse (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rx_valid(rx_valid),
    .rx_type(rx_type),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .p_valid(prs_valid),
    .p_type(prs_type),
    .p_node(p_node),
    .p_multicast_stream_id(p_multicast_stream_id),
    .p_peer(p_peer),
    .p_peer2(p_peer2),
    .p_tag(p_tag),
    .p_code(p_code),
    .p_count(p_count),
    .p_bw(p_bw),
    .p_rate(p_rate),
    .p_unsup(prs_unsup),
    .p_bad_len(prs_bad),
    .p_item_valid(p_item_valid),
    .p_item(p_item)
  );

  logic load;
  logic list_ph;
  logic gen_ok;
  mpc_pkg::mpc_msg_e ctype;

  always_comb begin
    ctype = mpc_pkg::mpc_msg_e'(cmd_type);
    load = !s_q.ov || tx_ready;
    list_ph = s_q.st == G_SEND && s_q.mt == mpc_pkg::MT_BROKEN && s_q.idx >= mpc_pkg::O_BL_LIST;
    gen_ok = list_ph ? list_valid : 1'b1;
    // confirm is held back until a release request has supplied its tag
    cmd_ready = s_q.st == G_IDLE && (ctype != mpc_pkg::MT_PREL_CNF || s_q.r_have);
    list_ready = list_ph && load;
    s_d = s_q;
    if (load) s_d.ov = 1'b0;
    // latest clean release request; its tag is echoed verbatim
    if (prs_valid && prs_type == 3'(mpc_pkg::MT_PREL_REQ) && !prs_unsup && !prs_bad) begin
      s_d.r_src = p_node;
      s_d.r_multicast_stream_id = p_multicast_stream_id;
      s_d.r_client = p_peer;
      s_d.r_tag = p_tag;
      s_d.r_have = 1'b1;
    end
    unique case (s_q.st)
      G_IDLE: begin
        if (cmd_valid && cmd_ready && ctype != mpc_pkg::MT_PREL_REQ) begin
          s_d.st = G_SEND;
          s_d.mt = ctype;
          s_d.idx = '0;
          s_d.len = mpc_pkg::msg_len(ctype, cmd_count);
          s_d.node = cmd_node;
          s_d.multicast_stream_id = cmd_multicast_stream_id;
          s_d.peer = cmd_peer;
          s_d.peer2 = cmd_peer2;
          s_d.cnt = cmd_count;
          s_d.bw = cmd_bw;
          s_d.rate = cmd_rate;
          s_d.dest = cmd_dest;
          s_d.tag = 8'h00;
          s_d.code = cmd_flag ? mpc_pkg::BW_DENIED : mpc_pkg::BW_APPROVED;
          unique case (ctype)
            mpc_pkg::MT_PREL_CNF: begin
              s_d.node = s_q.r_src;
              s_d.multicast_stream_id = s_q.r_multicast_stream_id;
              s_d.peer = s_q.r_client;
              s_d.tag = s_q.r_tag;
              s_d.code = cmd_flag ? mpc_pkg::RELAY_MEMBER : mpc_pkg::RELAY_LEFT;
            end
            mpc_pkg::MT_BROKEN: begin
              s_d.dest = cmd_node;
              s_d.code = cmd_flag ? mpc_pkg::BL_NO_BIND : mpc_pkg::BL_BROKEN;
            end
            default: ;
          endcase
        end
      end
      G_SEND: begin
        if (load && gen_ok) begin
          s_d.ov = 1'b1;
          s_d.od = list_ph ? list_data : build_octet(s_q);
          s_d.ol = s_q.idx == s_q.len - 9'h1;
          s_d.odest = s_q.dest;
          s_d.omt = s_q.mt;
          s_d.idx = s_q.idx + 9'h1;
          if (s_q.idx == s_q.len - 9'h1) s_d.st = G_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) s_q <= '0;
    else s_q <= s_d;
  end

  assign tx_valid = s_q.ov;
  assign tx_data = s_q.od;
  assign tx_last = s_q.ol;
  assign tx_dest = s_q.odest;
  assign rx_ready = 1'b1;
  assign p_valid = prs_valid;
  assign p_type = prs_type;
  assign p_unsup = prs_unsup;
  assign p_bad_len = prs_bad;
  assign tag_held = s_q.r_have;

  // octet position of the word on tx_data, for the checks below
  logic [8:0] oc_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) oc_q <= '0;
    else if (tx_valid && tx_ready) oc_q <= tx_last ? 9'h0 : oc_q + 9'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic hs;
  assign hs = tx_valid && tx_ready;

  chk_prel_len: assert property (
    hs && tx_last && s_q.omt == mpc_pkg::MT_PREL_CNF |-> oc_q == mpc_pkg::L_PR - 9'h1)
    else $error("path release confirm not five octets");
  chk_relay_code: assert property (
    tx_valid && s_q.omt == mpc_pkg::MT_PREL_CNF && oc_q == mpc_pkg::O_PR_STATE
    |-> tx_data <= mpc_pkg::RELAY_MEMBER)
    else $error("reserved relay state sent");
  chk_tag_echo: assert property (
    tx_valid && s_q.omt == mpc_pkg::MT_PREL_CNF && oc_q == mpc_pkg::O_PR_TAG
    |-> s_q.r_have && $past(s_q.r_have, 2) && tx_data == s_q.tag)
    else $error("confirm sent without a request tag");
  chk_ka_len: assert property (
    hs && tx_last && s_q.omt == mpc_pkg::MT_KEEPALIVE |-> oc_q == mpc_pkg::L_KA - 9'h1)
    else $error("keep-alive not two octets");
  chk_broken_dest: assert property (
    tx_valid && s_q.omt == mpc_pkg::MT_BROKEN && oc_q == mpc_pkg::O_PR_SRC
    |-> tx_data == tx_dest)
    else $error("broken-link notice not sent to source");
  chk_broken_code: assert property (
    tx_valid && s_q.omt == mpc_pkg::MT_BROKEN && oc_q == mpc_pkg::O_BL_STAT
    |-> tx_data <= mpc_pkg::CODE_MAX)
    else $error("reserved broken-link status sent");
  chk_broken_list: assert property (
    hs && tx_last && s_q.omt == mpc_pkg::MT_BROKEN |-> oc_q >= mpc_pkg::O_BL_CNT)
    else $error("broken-link notice too short");
  chk_rsv_len: assert property (
    hs && tx_last && s_q.omt == mpc_pkg::MT_RSV_REQ |-> oc_q == mpc_pkg::L_RQ - 9'h1)
    else $error("reserve request not nine octets");
  chk_cnf_code: assert property (
    tx_valid && s_q.omt == mpc_pkg::MT_RSV_CNF && oc_q == mpc_pkg::O_RC_STAT
    |-> tx_data <= mpc_pkg::CODE_MAX)
    else $error("reserved reserve status sent");
  chk_rel_len: assert property (
    hs && tx_last && s_q.omt == mpc_pkg::MT_REL_CNF |-> oc_q == mpc_pkg::L_RL - 9'h1)
    else $error("release confirm not two octets");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("octet changed while stalled");

  cov_prel: cover property (hs && tx_last && s_q.omt == mpc_pkg::MT_PREL_CNF);
  cov_list: cover property (list_valid && list_ready ##[1:20] hs && tx_last);
  cov_rsv: cover property (hs && tx_last && s_q.omt == mpc_pkg::MT_RSV_REQ);
  cov_unsup: cover property (prs_valid && prs_unsup);
endmodule : mpc_codec
`default_nettype wire

/* hw/mpc_pkg.sv */
// mpc_pkg: message types, octet positions and codes of the multicast path codec
// assumes one clock domain; octet k of a payload holds payload bits [8k+7:8k]
package mpc_pkg;
  typedef enum logic [2:0] {
    MT_PREL_REQ, MT_PREL_CNF, MT_KEEPALIVE, MT_BROKEN,
    MT_RSV_REQ, MT_RSV_CNF, MT_REL_REQ, MT_REL_CNF
  } mpc_msg_e;
  localparam int IDX_W = 9;
  localparam logic [8:0] O_PR_SRC = 9'h0;
  localparam logic [8:0] O_PR_MULTICAST_STREAM_ID = 9'h1;
  localparam logic [8:0] O_PR_CLIENT = 9'h2;
  localparam logic [8:0] O_PR_TAG = 9'h3;
  localparam logic [8:0] O_PR_STATE = 9'h4;
  localparam logic [8:0] O_BL_REP = 9'h1;
  localparam logic [8:0] O_BL_LOST = 9'h2;
  localparam logic [8:0] O_BL_STAT = 9'h3;
  localparam logic [8:0] O_BL_CNT = 9'h4;
  localparam logic [8:0] O_BL_LIST = 9'h5;
  localparam logic [8:0] O_RQ_GAP = 9'h2;
  localparam logic [8:0] O_RQ_BW = 9'h3;
  localparam logic [8:0] O_RQ_RATE = 9'h7;
  localparam logic [8:0] O_RC_STAT = 9'h0;
  localparam logic [8:0] O_RC_NODE = 9'h1;
  localparam logic [8:0] O_LC_MULTICAST_STREAM_ID = 9'h0;
  localparam logic [8:0] L_PR = 9'h5;
  localparam logic [8:0] L_KA = 9'h2;
  localparam logic [8:0] L_RQ = 9'h9;
  localparam logic [8:0] L_RC = 9'h3;
  localparam logic [8:0] L_RL = 9'h2;
  localparam logic [7:0] RELAY_LEFT = 8'h00;
  localparam logic [7:0] RELAY_MEMBER = 8'h01;
  localparam logic [7:0] BL_BROKEN = 8'h00;
  localparam logic [7:0] BL_NO_BIND = 8'h01;
  localparam logic [7:0] BW_APPROVED = 8'h00;
  localparam logic [7:0] BW_DENIED = 8'h01;
  localparam logic [7:0] CODE_MAX = 8'h01;
  localparam logic [7:0] RSV_GAP = 8'h00;

  // total payload length; lists add one octet per entry
  function automatic logic [8:0] msg_len(mpc_msg_e mt, logic [7:0] cnt);
    case (mt)
      MT_PREL_REQ, MT_BROKEN: msg_len = O_BL_LIST + {1'b0, cnt};
      MT_PREL_CNF: msg_len = L_PR;
      MT_RSV_REQ: msg_len = L_RQ;
      MT_RSV_CNF: msg_len = L_RC;
      MT_KEEPALIVE: msg_len = L_KA;
      default: msg_len = L_RL;
    endcase
  endfunction : msg_len
endpackage : mpc_pkg

/* hw/mpc_parse.sv */
// mpc_parse: splits received payload octets into fields and flags oddities
// assumes rx_type stands steady for a whole message and rx_last marks its end
`timescale 1ns/1ps
`default_nettype none
module mpc_parse (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [2:0] rx_type,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic p_valid,
  output logic [2:0] p_type,
  output logic [7:0] p_node,
  output logic [7:0] p_multicast_stream_id,
  output logic [7:0] p_peer,
  output logic [7:0] p_peer2,
  output logic [7:0] p_tag,
  output logic [7:0] p_code,
  output logic [7:0] p_count,
  output logic [31:0] p_bw,
  output logic [15:0] p_rate,
  output logic p_unsup,
  output logic p_bad_len,
  output logic p_item_valid,
  output logic [7:0] p_item
);
  typedef struct packed {
    logic [8:0] idx;
    mpc_pkg::mpc_msg_e mt;
    logic [7:0] node, multicast_stream_id, peer, peer2, tag, code, cnt, item;
    logic [31:0] bw;
    logic [15:0] rate;
    logic unsup, bad_len, done, item_v;
  } mpc_prs_s;

  mpc_prs_s s_q, s_d;

  always_comb begin
    mpc_pkg::mpc_msg_e mt;
    mt = (s_q.idx == '0) ? mpc_pkg::mpc_msg_e'(rx_type) : s_q.mt;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.item_v = 1'b0;
    if (rx_valid) begin
      if (s_q.idx == '0) begin
        s_d.unsup = 1'b0;
        s_d.mt = mt;
      end
      unique case (mt)
        mpc_pkg::MT_PREL_REQ, mpc_pkg::MT_PREL_CNF: begin
          case (s_q.idx)
            mpc_pkg::O_PR_SRC: s_d.node = rx_data;
            mpc_pkg::O_PR_MULTICAST_STREAM_ID: s_d.multicast_stream_id = rx_data;
            mpc_pkg::O_PR_CLIENT: s_d.peer = rx_data;
            mpc_pkg::O_PR_TAG: s_d.tag = rx_data;
            mpc_pkg::O_PR_STATE: begin
              s_d.code = rx_data;
              s_d.cnt = rx_data;
              if (mt == mpc_pkg::MT_PREL_CNF && rx_data > mpc_pkg::CODE_MAX)
                s_d.unsup = 1'b1;
            end
            default: begin
              s_d.item_v = (mt == mpc_pkg::MT_PREL_REQ);
              s_d.item = rx_data;
            end
          endcase
        end
        mpc_pkg::MT_BROKEN: begin
          case (s_q.idx)
            mpc_pkg::O_PR_SRC: s_d.node = rx_data;
            mpc_pkg::O_BL_REP: s_d.peer = rx_data;
            mpc_pkg::O_BL_LOST: s_d.peer2 = rx_data;
            mpc_pkg::O_BL_STAT: begin
              s_d.code = rx_data;
              if (rx_data > mpc_pkg::CODE_MAX) s_d.unsup = 1'b1;
            end
            mpc_pkg::O_BL_CNT: s_d.cnt = rx_data;
            default: begin
              s_d.item_v = 1'b1;
              s_d.item = rx_data;
            end
          endcase
        end
        mpc_pkg::MT_RSV_REQ: begin
          case (s_q.idx)
            mpc_pkg::O_PR_SRC: s_d.node = rx_data;
            mpc_pkg::O_PR_MULTICAST_STREAM_ID: s_d.multicast_stream_id = rx_data;
            // unspecified octet: not stored; any value but RSV_GAP flags unsup
            mpc_pkg::O_RQ_GAP: if (rx_data != mpc_pkg::RSV_GAP) s_d.unsup = 1'b1;
            mpc_pkg::O_RQ_BW: s_d.bw[7:0] = rx_data;
            mpc_pkg::O_RQ_BW + 9'h1: s_d.bw[15:8] = rx_data;
            mpc_pkg::O_RQ_BW + 9'h2: s_d.bw[23:16] = rx_data;
            mpc_pkg::O_RQ_BW + 9'h3: s_d.bw[31:24] = rx_data;
            mpc_pkg::O_RQ_RATE: s_d.rate[7:0] = rx_data;
            default: s_d.rate[15:8] = rx_data;
          endcase
        end
        mpc_pkg::MT_RSV_CNF: begin
          case (s_q.idx)
            mpc_pkg::O_RC_STAT: begin
              s_d.code = rx_data;
              if (rx_data > mpc_pkg::CODE_MAX) s_d.unsup = 1'b1;
            end
            mpc_pkg::O_RC_NODE: s_d.node = rx_data;
            default: s_d.multicast_stream_id = rx_data;
          endcase
        end
        mpc_pkg::MT_REL_CNF: begin
          if (s_q.idx == mpc_pkg::O_LC_MULTICAST_STREAM_ID) s_d.multicast_stream_id = rx_data;
          else s_d.node = rx_data;
        end
        default: begin
          // keep-alive and release request share octet 0 node, octet 1 stream
          if (s_q.idx == mpc_pkg::O_PR_SRC) s_d.node = rx_data;
          else s_d.multicast_stream_id = rx_data;
        end
      endcase
      if (rx_last) begin
        s_d.done = 1'b1;
        s_d.idx = '0;
        s_d.bad_len = (s_q.idx + 9'h1) != mpc_pkg::msg_len(mt, s_d.cnt);
      end else begin
        s_d.idx = s_q.idx + 9'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) s_q <= '0;
    else s_q <= s_d;
  end

  assign p_valid = s_q.done;
  assign p_type = s_q.mt;
  assign p_node = s_q.node;
  assign p_multicast_stream_id = s_q.multicast_stream_id;
  assign p_peer = s_q.peer;
  assign p_peer2 = s_q.peer2;
  assign p_tag = s_q.tag;
  assign p_code = s_q.code;
  assign p_count = s_q.cnt;
  assign p_bw = s_q.bw;
  assign p_rate = s_q.rate;
  assign p_unsup = s_q.unsup;
  assign p_bad_len = s_q.bad_len;
  assign p_item_valid = s_q.item_v;
  assign p_item = s_q.item;
endmodule : mpc_parse
`default_nettype wire

/* tb/mpc_peer_model.sv */
// mpc_peer_model: far-side management entity that takes outgoing payload octets
// assumes the tx_* handshake of mpc_codec; slow mode stalls tx_ready at random
`timescale 1ns/1ps
`default_nettype none
module mpc_peer_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [7:0] tx_dest,
  output var logic tx_ready
);
  logic [7:0] got_q[$];
  logic [7:0] last_dest;
  int frames = 0;

  // an octet counts only on an edge that sees valid and ready together
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        got_q.push_back(tx_data);
        if (tx_last) begin
          last_dest <= tx_dest;
          frames <= frames + 1;
        end
      end
      tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule : mpc_peer_model
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: random and corner-case traffic through both sides of mpc_codec
// assumes mpc_peer_model as the far side of the outgoing octet stream
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, rstn, cmd_valid, cmd_flag, list_valid, rx_valid, rx_last, slow;
  logic [2:0] cmd_type, rx_type, p_type;
  logic [7:0] cmd_node, cmd_multicast_stream_id, cmd_peer, cmd_peer2, cmd_count, cmd_dest, list_data, rx_data;
  logic [31:0] cmd_bw, p_bw;
  logic [15:0] cmd_rate, p_rate;
  logic cmd_ready, list_ready, tx_valid, tx_ready, tx_last, rx_ready, p_valid, p_unsup;
  logic p_bad_len, p_item_valid, tag_held;
  logic [7:0] tx_data, tx_dest, p_node, p_multicast_stream_id, p_peer, p_peer2, p_tag, p_code, p_count, p_item;
  logic [7:0] exp_q[$], items_q[$], lst[$], rxq[$], tg[4];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  mpc_codec i_mpc_codec (.ref_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_type, .cmd_node,
    .cmd_multicast_stream_id, .cmd_peer, .cmd_peer2, .cmd_flag, .cmd_count, .cmd_bw, .cmd_rate, .cmd_dest,
    .list_valid, .list_ready, .list_data, .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_dest,
    .rx_valid, .rx_ready, .rx_type, .rx_data, .rx_last, .p_valid, .p_type, .p_node, .p_multicast_stream_id,
    .p_peer, .p_peer2, .p_tag, .p_code, .p_count, .p_bw, .p_rate, .p_unsup, .p_bad_len,
    .p_item_valid, .p_item, .tag_held);
  mpc_peer_model i_mpc_peer_model (.ref_clk, .rstn, .slow, .tx_valid, .tx_data, .tx_last,
    .tx_dest, .tx_ready);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  always @(posedge ref_clk) begin
    if (p_item_valid) items_q.push_back(p_item);
  end

  function automatic void build_exp();
    case (cmd_type)
      3'd1: exp_q = {tg[0], tg[1], tg[2], tg[3], 8'(cmd_flag)};
      3'd2, 3'd6: exp_q = {cmd_node, cmd_multicast_stream_id};
      3'd3: exp_q = {cmd_node, cmd_peer, cmd_peer2, 8'(cmd_flag), cmd_count, lst};
      3'd4: exp_q = {cmd_node, cmd_multicast_stream_id, 8'h00, cmd_bw[7:0], cmd_bw[15:8], cmd_bw[23:16],
                     cmd_bw[31:24], cmd_rate[7:0], cmd_rate[15:8]};
      3'd5: exp_q = {8'(cmd_flag), cmd_node, cmd_multicast_stream_id};
      default: exp_q = {cmd_multicast_stream_id, cmd_node};
    endcase
  endfunction : build_exp

  task automatic build(input logic [2:0] t, input int n);
    int f0, k;
    f0 = i_mpc_peer_model.frames;
    i_mpc_peer_model.got_q = {};
    lst = {};
    repeat (n) lst.push_back(8'($urandom));
    @(posedge ref_clk);
    {cmd_node, cmd_multicast_stream_id, cmd_peer, cmd_peer2} <= $urandom;
    {cmd_bw, cmd_rate, cmd_dest} <= 56'({$urandom, $urandom});
    cmd_flag <= 1'($urandom);
    cmd_type <= t;
    cmd_count <= 8'(n);
    cmd_valid <= 1'b1;
    k = 0;
    @(negedge ref_clk);
    while (!cmd_ready && k++ < 100) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    foreach (lst[i]) begin
      list_valid <= 1'b1;
      list_data <= lst[i];
      k = 0;
      @(negedge ref_clk);
      while (!list_ready && k++ < 100) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    list_valid <= 1'b0;
    k = 0;
    while (i_mpc_peer_model.frames == f0 && k++ < 300) @(negedge ref_clk);
    build_exp();
    check("tx length", i_mpc_peer_model.got_q.size(), exp_q.size());
    foreach (exp_q[i]) check("tx octet", i_mpc_peer_model.got_q[i], exp_q[i]);
    check("tx dest", i_mpc_peer_model.last_dest, t == 3'd3 ? cmd_node : cmd_dest);
  endtask : build

  task automatic rx_test(input logic [2:0] t, input bit bad);
    int n, len;
    n = (t == 3'd0 || t == 3'd3) ? $urandom_range(3) : 0;
    case (t)
      3'd0, 3'd1, 3'd3: len = 5 + n;
      3'd4: len = 9;
      3'd5: len = 3;
      default: len = 2;
    endcase
    rxq = {};
    repeat (len + int'(bad)) rxq.push_back(8'($urandom));
    if (n > 0 || t == 3'd0 || t == 3'd3) rxq[4] = 8'(n);
    if (t == 3'd1) rxq[4] = 8'($urandom_range(3));
    if (t == 3'd3) rxq[3] = 8'($urandom_range(3));
    if (t == 3'd5) rxq[0] = 8'($urandom_range(3));
    if (t == 3'd4 && $urandom_range(1)) rxq[2] = 8'h00;
    items_q = {};
    foreach (rxq[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_type <= t;
      rx_data <= rxq[i];
      rx_last <= (i == rxq.size() - 1);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    @(negedge ref_clk);
    check("p_valid", p_valid, 1);
    check("p_type", p_type, t);
    check("p_bad_len", p_bad_len, bad);
    if (!bad) begin
      case (t)
        3'd0, 3'd1: begin
          check("p_node", p_node, rxq[0]);
          check("p_multicast_stream_id", p_multicast_stream_id, rxq[1]);
          check("p_peer", p_peer, rxq[2]);
          check("p_tag", p_tag, rxq[3]);
          check("p_code", p_code, rxq[4]);
          if (t == 3'd1) check("p_unsup", p_unsup, rxq[4] > 8'h01);
          if (t == 3'd0) tg = '{rxq[0], rxq[1], rxq[2], rxq[3]};
        end
        3'd3: begin
          check("p_node", p_node, rxq[0]);
          check("p_peer", p_peer, rxq[1]);
          check("p_peer2", p_peer2, rxq[2]);
          check("p_code", p_code, rxq[3]);
          check("p_unsup", p_unsup, rxq[3] > 8'h01);
          check("p_count", p_count, rxq[4]);
        end
        3'd4: begin
          check("p_node", p_node, rxq[0]);
          check("p_multicast_stream_id", p_multicast_stream_id, rxq[1]);
          check("p_bw", p_bw, {rxq[6], rxq[5], rxq[4], rxq[3]});
          check("p_rate", p_rate, {rxq[8], rxq[7]});
          check("p_unsup", p_unsup, rxq[2] != 8'h00);
        end
        3'd5: begin
          check("p_code", p_code, rxq[0]);
          check("p_node", p_node, rxq[1]);
          check("p_multicast_stream_id", p_multicast_stream_id, rxq[2]);
          check("p_unsup", p_unsup, rxq[0] > 8'h01);
        end
        3'd7: begin
          check("p_multicast_stream_id", p_multicast_stream_id, rxq[0]);
          check("p_node", p_node, rxq[1]);
        end
        default: begin
          check("p_node", p_node, rxq[0]);
          check("p_multicast_stream_id", p_multicast_stream_id, rxq[1]);
        end
      endcase
      // the collector pushes the last item on this edge; look only once it has run
      @(posedge ref_clk);
      @(negedge ref_clk);
      if (t == 3'd0 || t == 3'd3) check("item count", items_q.size(), n);
      foreach (items_q[i]) check("p_item", items_q[i], rxq[5 + i]);
      if (t == 3'd0) check("tag_held", tag_held, 1);
    end
  endtask : rx_test

  initial begin
    {rstn, cmd_valid, cmd_flag, list_valid, rx_valid, rx_last, slow} = '0;
    {cmd_type, rx_type, cmd_node, cmd_multicast_stream_id, cmd_peer, cmd_peer2, cmd_count} = '0;
    {cmd_dest, list_data, rx_data, cmd_bw, cmd_rate} = '0;
    void'($urandom(74));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check("rx_ready", rx_ready, 1);
    check("tx_valid", tx_valid, 0);
    check("cmd_ready", cmd_ready, 1);
    @(posedge ref_clk);
    cmd_type <= 3'd1;
    @(negedge ref_clk);
    // nothing captured yet, so a release confirm has no tag to echo
    check("cmd_ready", cmd_ready, 0);
    $display("test reset done");
    repeat (4) begin
      for (int t = 0; t < 8; t++) rx_test(3'(t), 1'b0);
    end
    rx_test(3'd2, 1'b1);
    rx_test(3'd6, 1'b1);
    $display("test receive done");
    for (int s = 0; s < 2; s++) begin
      slow <= 1'(s);
      for (int t = 1; t < 8; t++) build(3'(t), t == 3 ? 4 * s : 0);
      build(3'd3, $urandom_range(1, 3));
    end
    $display("test transmit done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
